// File: hdl/nps_pkg.sv
/*
 * shared constants, field layouts and state codes of the two-wire slave
 * of a triple nonvolatile potentiometer.
 * assumes a 25 MHz system clock and an external bus master driving scl.
 */
package nps_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ                    = 25000;
    localparam int INTERNAL_WRITE_DURATION_US = 10;
    localparam int INTERNAL_WRITE_CYCLES      =
        (INTERNAL_WRITE_DURATION_US * CLK_KHZ + 999) / 1000;

    // ------------------------------------------------------------
    // address byte and memory layout
    // ------------------------------------------------------------
    localparam logic [5:0] DEV_PREFIX  = 6'h28;
    localparam logic [7:0] PTR_RESET   = 8'h00;
    localparam logic [7:0] POT_BASE    = 8'hF8;
    localparam logic [7:0] POS_MASK    = 8'h7F;
    localparam int         POT_NUM     = 3;
    localparam int         MEM_DEPTH   = 256;
    localparam int         FIFO_DEPTH  = 32;
    localparam int         FIFO_WIDTH  = 16;
    localparam logic [3:0] BITS_BYTE   = 4'h8;
    localparam logic [3:0] BIT_LAST    = 4'h7;
    localparam logic [2:0] PAGE_STEP   = 3'h1;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_DEVADR = 3'b001,
        ST_ACK    = 3'b010,
        ST_MEMADR = 3'b011,
        ST_WDATA  = 3'b100,
        ST_RDATA  = 3'b101,
        ST_RACK   = 3'b110
    } nps_state_e;

endpackage

// File: hdl/nps_fifo_if.sv
/*
 * handshake bundle between the slave and its write buffer.
 * assumes both ends run on sys_clk.
 */
`timescale 1ns/1ps
interface nps_fifo_if #(parameter int W = 16);
    logic         pushValid;
    logic         pushReady;
    logic [W-1:0] pushData;
    logic         popValid;
    logic         popReady;
    logic [W-1:0] popData;
    logic         clear;

    modport store (input  pushValid, pushData, popReady, clear,
                   output pushReady, popValid, popData);
    modport user  (output pushValid, pushData, popReady, clear,
                   input  pushReady, popValid, popData);
endinterface

// File: hdl/nps_sync.sv
/*
 * two-flop synchroniser, one per bit.
 * assumes inputs asynchronous to sys_clk.
 */
`timescale 1ns/1ps
module nps_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                meta_q[i] <= RST_VAL[i];
                sync_q[i] <= RST_VAL[i];
            end else begin
                meta_q[i] <= asyncIn[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    assign syncOut = sync_q;
endmodule // nps_sync

// File: hdl/nps_fifo.sv
/*
 * first-in first-out buffer with valid and ready on both sides.
 * assumes single clock; clear empties it in one cycle.
 */
`timescale 1ns/1ps
module nps_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic   sys_clk,
    input  wire logic   resetn,
    nps_fifo_if.store   port
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q, wr_d;
    logic [AW:0]      rd_q, rd_d;
    logic             full;
    logic             empty;
    logic             doPush;
    logic             doPop;

    always_comb begin
        empty  = (wr_q == rd_q);
        full   = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
        doPush = port.pushValid && !full && !port.clear;
        doPop  = port.popReady && !empty && !port.clear;
        wr_d   = wr_q;
        rd_d   = rd_q;
        if (port.clear) begin
            wr_d = '0;
            rd_d = '0;
        end else begin
            if (doPush) begin
                wr_d = wr_q + 1'b1;
            end
            if (doPop) begin
                rd_d = rd_q + 1'b1;
            end
        end
    end

    assign port.pushReady = !full;
    assign port.popValid  = !empty;
    assign port.popData   = mem[rd_q[AW-1:0]];

    always_ff @(posedge sys_clk) begin
        if (doPush) begin
            mem[wr_q[AW-1:0]] <= port.pushData;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end
endmodule // nps_fifo

// File: hdl/nps_two_wire_slave.sv
/*
 * two-wire slave of a triple nonvolatile potentiometer: address match,
 * byte and page writes through a commit buffer, timed nonvolatile write,
 * current, random and sequential reads, write-protected wiper positions.
 * assumes an external master drives scl and a pull-up holds both lines.
 */
`timescale 1ns/1ps
module nps_two_wire_slave
    import nps_pkg::*;
#(
    parameter int INTERNAL_WRITE_CYCLES_P = INTERNAL_WRITE_CYCLES
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             sclIn,
    input  wire logic             sdaIn,
    output logic                  sdaOut,
    output logic                  sdaOe,
    input  wire logic             deviceSelectInput,
    input  wire logic             writeProtect,
    output logic [POT_NUM-1:0][6:0] potPos,
    output logic                  writeBusy
);
    localparam int TW = $clog2(INTERNAL_WRITE_CYCLES_P + 1);
    localparam logic [TW-1:0] TIMER_LAST =
        TW'(INTERNAL_WRITE_CYCLES_P - 1);

    // ------------------------------------------------------------
    // pin sampling and bus conditions
    // ------------------------------------------------------------
    logic       sclS;
    logic       sdaS;
    logic       selS;
    logic       wpS;
    logic       sclP_q;
    logic       sdaP_q;
    logic       sclRise;
    logic       sclFall;
    logic       startCond;
    logic       stopCond;

    nps_sync #(.W(4), .RST_VAL(4'hD)) u_sync (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .asyncIn ({sclIn, sdaIn, deviceSelectInput, writeProtect}),
        .syncOut ({sclS, sdaS, selS, wpS})
    );

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sclP_q <= 1'b1;
            sdaP_q <= 1'b1;
        end else begin
            sclP_q <= sclS;
            sdaP_q <= sdaS;
        end
    end

    assign sclRise   = sclS && !sclP_q;
    assign sclFall   = !sclS && sclP_q;
    assign startCond = sclS && sclP_q && sdaP_q && !sdaS;
    assign stopCond  = sclS && sclP_q && !sdaP_q && sdaS;

    // ------------------------------------------------------------
    // write buffer
    // ------------------------------------------------------------
    nps_fifo_if #(.W(FIFO_WIDTH)) fifo ();

    nps_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .port    (fifo.store)
    );

    // ------------------------------------------------------------
    // memory and wiper positions
    // ------------------------------------------------------------
    logic [7:0]       mem [MEM_DEPTH];
    logic [7:0]       memRd;
    logic [7:0]       wrAddr;
    logic [7:0]       wrData;
    logic             isPot;
    logic             memWe;
    logic [POT_NUM-1:0][6:0] potPos_q, potPos_d;

    assign wrAddr = fifo.popData[15:8];
    assign wrData = fifo.popData[7:0];
    assign isPot  = (wrAddr >= POT_BASE) &&
                    (wrAddr < POT_BASE + 8'(POT_NUM));

    // positions stay locked unless protect is low
    assign memWe = writeBusy && fifo.popValid && !(isPot && wpS);

    always_ff @(posedge sys_clk) begin
        if (memWe) begin
            mem[wrAddr] <= isPot ? (wrData & POS_MASK) : wrData;
        end
    end

    for (genvar i = 0; i < POT_NUM; i++) begin : g_pot
        assign potPos_d[i] = (memWe && wrAddr == POT_BASE + 8'(i)) ?
                             wrData[6:0] : potPos_q[i];
    end

    // ------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------
    nps_state_e state_q, state_d;
    nps_state_e after_q, after_d;
    logic [3:0] bitCnt_q, bitCnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] ptr_q, ptr_d;
    logic       oe_q, oe_d;
    logic       mAck_q, mAck_d;
    logic       busy_q, busy_d;
    logic [TW-1:0] timer_q, timer_d;
    logic       doLoad;
    logic       addrMatch;
    logic       byteDone;

    assign memRd     = mem[ptr_q];
    assign byteDone  = sclFall && bitCnt_q == BITS_BYTE;
    assign addrMatch = shift_q[7:2] == DEV_PREFIX &&
                       shift_q[1] == selS && !busy_q;

    always_comb begin
        state_d        = state_q;
        after_d        = after_q;
        bitCnt_d       = bitCnt_q;
        shift_d        = shift_q;
        ptr_d          = ptr_q;
        oe_d           = oe_q;
        mAck_d         = mAck_q;
        busy_d         = busy_q;
        timer_d        = timer_q;
        doLoad         = 1'b0;
        fifo.pushValid = 1'b0;
        fifo.pushData  = {ptr_q, shift_q};
        fifo.popReady  = busy_q;
        fifo.clear     = 1'b0;

        if (busy_q) begin
            timer_d = timer_q + 1'b1;
            if (timer_q == TIMER_LAST) begin
                busy_d  = 1'b0;
                timer_d = '0;
            end
        end

        if (startCond) begin
            state_d  = ST_DEVADR;
            bitCnt_d = '0;
            oe_d     = 1'b0;
            // bytes not closed by a stop are dropped
            fifo.clear = !busy_q;
        end else if (stopCond) begin
            state_d = ST_IDLE;
            oe_d    = 1'b0;
            if (fifo.popValid && !busy_q) begin
                busy_d  = 1'b1;
                timer_d = '0;
            end
        end else if (sclRise) begin
            if (state_q == ST_RACK) begin
                mAck_d = !sdaS;
            end else if (state_q == ST_DEVADR || state_q == ST_MEMADR ||
                         state_q == ST_WDATA) begin
                if (bitCnt_q != BITS_BYTE) begin
                    shift_d  = {shift_q[6:0], sdaS};
                    bitCnt_d = bitCnt_q + 4'h1;
                end
            end
        end else if (sclFall) begin
            case (state_q)
                ST_DEVADR: begin
                    if (byteDone) begin
                        if (addrMatch) begin
                            oe_d    = 1'b1;
                            state_d = ST_ACK;
                            after_d = shift_q[0] ? ST_RDATA
                                                 : ST_MEMADR;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end
                end
                ST_MEMADR: begin
                    if (byteDone) begin
                        ptr_d   = shift_q;
                        oe_d    = 1'b1;
                        state_d = ST_ACK;
                        after_d = ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (byteDone) begin
                        if (fifo.pushReady) begin
                            fifo.pushValid = 1'b1;
                            ptr_d   = {ptr_q[7:3],
                                       ptr_q[2:0] + PAGE_STEP};
                            oe_d    = 1'b1;
                            state_d = ST_ACK;
                            after_d = ST_WDATA;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end
                end
                ST_ACK: begin
                    // ack held from one fall to the next
                    oe_d     = 1'b0;
                    bitCnt_d = '0;
                    state_d  = after_q;
                    doLoad   = (after_q == ST_RDATA);
                end
                ST_RDATA: begin
                    if (bitCnt_q == BIT_LAST) begin
                        oe_d    = 1'b0;
                        state_d = ST_RACK;
                    end else begin
                        shift_d  = {shift_q[6:0], 1'b0};
                        oe_d     = !shift_q[6];
                        bitCnt_d = bitCnt_q + 4'h1;
                    end
                end
                ST_RACK: begin
                    if (mAck_q) begin
                        doLoad = 1'b1;
                    end else begin
                        state_d = ST_IDLE;
                        oe_d    = 1'b0;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
            if (doLoad) begin
                shift_d  = memRd;
                oe_d     = !memRd[7];
                ptr_d    = ptr_q + 8'h01;
                bitCnt_d = '0;
                state_d  = ST_RDATA;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q  <= ST_IDLE;
            after_q  <= ST_IDLE;
            bitCnt_q <= '0;
            shift_q  <= '0;
            ptr_q    <= PTR_RESET;
            oe_q     <= 1'b0;
            mAck_q   <= 1'b0;
            busy_q   <= 1'b0;
            timer_q  <= '0;
            potPos_q <= '0;
        end else begin
            state_q  <= state_d;
            after_q  <= after_d;
            bitCnt_q <= bitCnt_d;
            shift_q  <= shift_d;
            ptr_q    <= ptr_d;
            oe_q     <= oe_d;
            mAck_q   <= mAck_d;
            busy_q   <= busy_d;
            timer_q  <= timer_d;
            potPos_q <= potPos_d;
        end
    end

    // open drain: only ever pulls low
    assign sdaOut    = 1'b0;
    assign sdaOe     = oe_q;
    assign writeBusy = busy_q;
    assign potPos    = potPos_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_start;
        startCond |=> state_q == ST_DEVADR && bitCnt_q == 4'h0;
    endproperty
    a_start: assert property (p_start)
        else $error("start not taken");

    property p_stop;
        stopCond |=> state_q == ST_IDLE && !sdaOe;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not release the bus");

    property p_mismatch;
        state_q == ST_DEVADR && byteDone && shift_q[1] != selS
            |=> state_q == ST_IDLE && !sdaOe;
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("acknowledged a foreign select bit");

    property p_busy_nack;
        state_q == ST_DEVADR && byteDone && busy_q |=> !sdaOe;
    endproperty
    a_busy_nack: assert property (p_busy_nack)
        else $error("address acknowledged during write");

    property p_dir;
        state_q == ST_DEVADR && byteDone && addrMatch
            |=> after_q == ($past(shift_q[0]) ? ST_RDATA : ST_MEMADR);
    endproperty
    a_dir: assert property (p_dir)
        else $error("direction bit misread");

    property p_ack_low;
        $rose(state_q == ST_ACK) |-> sdaOe;
    endproperty
    a_ack_low: assert property (p_ack_low)
        else $error("ack clock without sda low");

    property p_sda_scl_low;
        $changed(sdaOe) && !$past(startCond) && !$past(stopCond)
            |-> !sclS;
    endproperty
    a_sda_scl_low: assert property (p_sda_scl_low)
        else $error("sda moved while scl high");

    property p_page;
        fifo.pushValid |=> ptr_q[7:3] == $past(ptr_q[7:3]);
    endproperty
    a_page: assert property (p_page)
        else $error("page write left its page");

    property p_commit;
        $rose(busy_q) |-> $past(stopCond);
    endproperty
    a_commit: assert property (p_commit)
        else $error("write committed without stop");

    property p_wp;
        $changed(potPos_q) |-> !$past(wpS);
    endproperty
    a_wp: assert property (p_wp)
        else $error("position changed while protected");

    property p_rd_inc;
        doLoad |=> ptr_q == $past(ptr_q) + 8'h01;
    endproperty
    a_rd_inc: assert property (p_rd_inc)
        else $error("read pointer did not advance");

    property p_nack_end;
        state_q == ST_RACK && sclFall && !mAck_q && !startCond && !stopCond
            |=> state_q == ST_IDLE && !sdaOe;
    endproperty
    a_nack_end: assert property (p_nack_end)
        else $error("read continued after master nack");

    property p_timer;
        busy_q |-> timer_q <= TIMER_LAST;
    endproperty
    a_timer: assert property (p_timer)
        else $error("write timer overran");
endmodule // nps_two_wire_slave

// File: verification/nps_master_bfm.sv
/*
 * behavioural two-wire bus master that drives scl and pulls sda low.
 * assumes sda is resolved outside with a pull-up; bit period 8 sys_clk.
 */
`timescale 1ns/1ps
// ------------------------------------------------------------
// bus master model
// ------------------------------------------------------------
module nps_master_bfm (
    input  wire logic sys_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sdaLow
);
    // scl stands high between frames
    initial begin
        scl    = 1'b1;
        sdaLow = 1'b0;
    end

    // also serves as repeated start; ends with scl low
    task automatic start();
        @(negedge sys_clk) sdaLow = 1'b0;
        repeat (4) @(negedge sys_clk);
        scl = 1'b1;
        repeat (4) @(negedge sys_clk);
        sdaLow = 1'b1;
        repeat (4) @(negedge sys_clk);
        scl = 1'b0;
    endtask

    task automatic stop();
        @(negedge sys_clk) sdaLow = 1'b1;
        repeat (4) @(negedge sys_clk);
        scl = 1'b1;
        repeat (4) @(negedge sys_clk);
        sdaLow = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask

    // sda moves only in the low phase, sampled inside the high phase
    task automatic xbit(input logic b, output logic s);
        @(negedge sys_clk) sdaLow = ~b;
        repeat (4) @(negedge sys_clk);
        scl = 1'b1;
        repeat (2) @(negedge sys_clk);
        s = sda;
        @(negedge sys_clk) scl = 1'b0;
    endtask

    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            xbit(tx[i], rx[i]);
        end
    endtask
endmodule // nps_master_bfm

// File: verification/nv_pot_two_wire_slave_tb_top.sv
/*
 * self-checking bench of the two-wire potentiometer slave.
 * assumes the bus master model and a pull-up on sda.
 */
`timescale 1ns/1ps
module nv_pot_two_wire_slave_tb_top
    import nps_pkg::*;
;
    logic                   sys_clk = 1'b0;
    logic                   resetn  = 1'b0;
    logic                   selIn   = 1'b1;
    logic                   protIn  = 1'b1;
    logic                   scl;
    logic                   sdaLow;
    logic                   sdaOut;
    logic                   sdaOe;
    logic                   writeBusy;
    logic [POT_NUM-1:0][6:0] potPos;
    wire                    sda = (sdaOe ? sdaOut : 1'b1) & ~sdaLow;
    int                     nErrors  = 0;
    int                     nTests   = 0;
    int                     cyc      = 0;

    nps_two_wire_slave #(.INTERNAL_WRITE_CYCLES_P(300)) dut_u (
        .sys_clk(sys_clk), .resetn(resetn), .sclIn(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .deviceSelectInput(selIn),
        .writeProtect(protIn), .potPos(potPos), .writeBusy(writeBusy));

    nps_master_bfm m_u (.sys_clk(sys_clk), .sda(sda), .scl(scl),
                        .sdaLow(sdaLow));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic closeOut();
        if (nErrors == 0 && nTests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        nTests++;
        if (g !== e) begin
            nErrors++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask

    function automatic logic [7:0] adrB(input logic sel, input logic rd);
        return {DEV_PREFIX, sel, rd};
    endfunction

    task automatic sendB(input logic [7:0] b, input logic ackd,
                         input string nm);
        logic [7:0] rx;
        logic       a;
        m_u.xbyte(b, rx);
        m_u.xbit(1'b1, a);
        chk(nm, {7'h00, ~ackd}, {7'h00, a});
    endtask

    task automatic beginW(input logic [7:0] ma);
        m_u.start();
        sendB(adrB(1'b1, 1'b0), 1'b1, "addrW");
        sendB(ma, 1'b1, "memAdr");
    endtask

    task automatic waitIdle();
        for (int i = 0; i < 400 && writeBusy !== 1'b0; i++)
            @(negedge sys_clk);
        chk("idle", 8'h00, {7'h00, writeBusy});
    endtask

    task automatic wrMem(input logic [7:0] ma, input logic [7:0] d [$]);
        beginW(ma);
        foreach (d[i]) sendB(d[i], 1'b1, "data");
        m_u.stop();
        waitIdle();
    endtask

    task automatic rdSeq(input logic [7:0] ma, input logic [7:0] e [$],
                         input logic rnd);
        logic [7:0] rx;
        logic       dm;
        if (rnd) beginW(ma);
        m_u.start();
        sendB(adrB(1'b1, 1'b1), 1'b1, "addrR");
        foreach (e[i]) begin
            m_u.xbyte(8'hFF, rx);
            m_u.xbit(i == e.size() - 1, dm);
            chk("rdData", e[i], rx);
        end
        m_u.stop();
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_addr();
        m_u.start();
        sendB({6'h29, 1'b1, 1'b0}, 1'b0, "badPrefix");
        m_u.start();
        sendB(adrB(1'b0, 1'b0), 1'b0, "badSel");
        m_u.stop();
        selIn = 1'b0;
        repeat (8) @(negedge sys_clk);
        m_u.start();
        sendB(adrB(1'b0, 1'b0), 1'b1, "sel0");
        m_u.stop();
        waitIdle();
        selIn = 1'b1;
        repeat (8) @(negedge sys_clk);
    endtask

    task automatic t_write();
        beginW(8'h10);
        sendB(8'h5A, 1'b1, "data0");
        sendB(8'hC3, 1'b1, "data1");
        m_u.stop();
        chk("busy", 8'h01, {7'h00, writeBusy});
        m_u.start();
        sendB(adrB(1'b1, 1'b0), 1'b0, "poll");
        m_u.stop();
        waitIdle();
        rdSeq(8'h10, '{8'h5A}, 1'b1);
        rdSeq(8'h00, '{8'hC3}, 1'b0);
    endtask

    task automatic t_page();
        logic [7:0] d [$];
        for (int i = 0; i < 8; i++) d.push_back(8'h80 + i);
        wrMem(8'h2C, d);
        rdSeq(8'h28, '{8'h84, 8'h85, 8'h86, 8'h87,
                       8'h80, 8'h81, 8'h82, 8'h83}, 1'b1);
    endtask

    task automatic t_discard();
        wrMem(8'h40, '{8'h11});
        beginW(8'h40);
        sendB(8'h22, 1'b1, "dropData");
        rdSeq(8'h40, '{8'h11}, 1'b1);
        chk("noCommit", 8'h00, {7'h00, writeBusy});
    endtask

    task automatic t_wrap();
        wrMem(8'hFF, '{8'h55});
        wrMem(8'h00, '{8'h66});
        rdSeq(8'hFF, '{8'h55, 8'h66}, 1'b1);
    endtask

    task automatic t_pots();
        chk("pot0Rst", 8'h00, {1'b0, potPos[0]});
        wrMem(POT_BASE, '{8'h85});
        chk("pot0Lock", 8'h00, {1'b0, potPos[0]});
        protIn = 1'b0;
        repeat (4) @(negedge sys_clk);
        wrMem(POT_BASE, '{8'h85, 8'h7F, 8'h01});
        chk("pot0", 8'h05, {1'b0, potPos[0]});
        chk("pot1", 8'h7F, {1'b0, potPos[1]});
        chk("pot2", 8'h01, {1'b0, potPos[2]});
        rdSeq(POT_BASE, '{8'h05}, 1'b1);
    endtask

    // ------------------------------------------------------------
    // clock, timeout and main sequence
    // ------------------------------------------------------------
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            nErrors++;
            $display("ERROR timeout exp done got hang");
            closeOut();
        end
    end

    initial begin
        repeat (6) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (10) @(negedge sys_clk);
        t_addr();
        t_write();
        t_page();
        t_discard();
        t_wrap();
        t_pots();
        closeOut();
    end
endmodule // nv_pot_two_wire_slave_tb_top
